// ---- rtl/oneshot_timer.sv ----
// Purpose: Four chained one-shot timers with register port and interrupt
// Assumes: Register strobes one cycle long, read data one cycle later
// Notes:   Reads of unmapped addresses return zero; writes there are dropped
//
// How it works
// [R01] Each shot raises at most one interrupt, not a periodic stream.
// [R02] A shot starts from the enable bit alone or from enable with a chain or pin trigger.
// [R03] Triggers arriving while enable is clear are ignored.
// [R04] Hardware clears enable at the first count tick after start.
// [R05] Every start loads the reload value, then counts down only.
// [R06] Underflow halts the counter; it never wraps or restarts.
// [R07] The reload-on-wrap select bit is stored but steers nothing.
// [R08] Counting stops on underflow or on a written reset bit.
// [R09] The interrupt request fires at the underflow moment.
// [R10] In event mode, preceding timer overflow replaces the tick.
// [R11] Pulse output is high from start until the count stops.
// [R12] The count register always reads the live counter value.
// [R13] Writing the reset bit copies reload into the counter at once.
// [R14] Without reset, a new reload value enters only at the next start or at underflow.
// [R15] Software writes enable after programming reload.
// [R16] The event input pin may serve as the shot trigger.
// [R17] Sixteen-bit counters, four instances, underflows chained in order.
// [R18] One decrement per tick; interrupt flag sticks until cleared.
`timescale 1ns/10ps
module oneshot_timer (
  input  wire logic                            core_clk,
  input  wire logic                            rst_b,
  input  wire logic [7:0]                      regAddr,
  input  wire logic [oneshot_pkg::CW-1:0]      regWrData,
  input  wire logic                            regWrEn,
  input  wire logic                            regRdEn,
  output logic      [oneshot_pkg::CW-1:0]      regRdData,
  input  wire logic                            chainIn,
  input  wire logic [oneshot_pkg::TIMERS-1:0]  timerEventInputPin,
  output logic      [oneshot_pkg::TIMERS-1:0]  timerPulseOutputPin,
  output logic                                 chainOut,
  output logic                                 irq
);

  localparam int N  = oneshot_pkg::TIMERS;
  localparam int CW = oneshot_pkg::CW;

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [N-1:0]  enable_q;
  logic [N-1:0]  startSel_q;
  logic [N-1:0]  extTrig_q;
  logic [N-1:0]  evtMode_q;
  logic [N-1:0]  rldWrap_q;
  logic [CW-1:0] reload_q [N];
  logic [N-1:0]  status_q;
  logic [N-1:0]  mask_q;
  logic [CW-1:0] rdData_q;

  logic [CW-1:0] count     [N];
  logic [CW-1:0] ctrlView  [N];
  logic [N-1:0]  running;
  logic [N-1:0]  underflow;
  logic [N-1:0]  enableClr;
  logic [N:0]    chain;
  logic [N-1:0]  rstPulse;
  logic [N-1:0]  wrCtrl;
  logic [N-1:0]  wrReload;
  logic          tick;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire       inTimers = (regAddr[7:6] == 2'b00);
  wire [1:0] tSel     = regAddr[5:4];
  wire [3:0] rSel     = regAddr[3:0];
  wire       wrStatus = regWrEn & (regAddr == oneshot_pkg::REG_STATUS);
  wire       wrMask   = regWrEn & (regAddr == oneshot_pkg::REG_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Timer tick

  tick_divider uDiv (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .tickPulse (tick)
  );

  // Chain head comes from outside; each underflow feeds the next timer
  assign chain[0] = chainIn;                                     // [R17]
  assign chainOut = chain[N];

  ////////////////////////////////////////////////////////////////////////////
  // Per-timer register slices and counters

  for (genvar i = 0; i < N; i++) begin : gT
    localparam logic [1:0] IDX = 2'(i);

    // Strobe decode for this timer
    assign wrCtrl[i]   = regWrEn & inTimers & (tSel == IDX) & (rSel == oneshot_pkg::REG_CTRL);
    assign wrReload[i] = regWrEn & inTimers & (tSel == IDX) & (rSel == oneshot_pkg::REG_RELOAD);
    assign rstPulse[i] = wrCtrl[i] & regWrData[oneshot_pkg::CTRL_RESET];   // [R08] [R13]

    // Control readback; reset bit is an action and reads zero
    assign ctrlView[i] = {
      7'h00, running[i], 2'b00, rldWrap_q[i], evtMode_q[i],
      extTrig_q[i], startSel_q[i], 1'b0, enable_q[i]
    };

    // Control fields; enable cleared by hardware after start or by reset
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        enable_q[i]   <= 1'b0;
        startSel_q[i] <= 1'b0;
        extTrig_q[i]  <= 1'b0;
        evtMode_q[i]  <= 1'b0;
        rldWrap_q[i]  <= 1'b0;
      end else if (wrCtrl[i]) begin
        enable_q[i]   <= regWrData[oneshot_pkg::CTRL_ENABLE] & ~rstPulse[i];
        startSel_q[i] <= regWrData[oneshot_pkg::CTRL_STARTSEL];
        extTrig_q[i]  <= regWrData[oneshot_pkg::CTRL_EXTTRIG];
        evtMode_q[i]  <= regWrData[oneshot_pkg::CTRL_EVTMODE];
        rldWrap_q[i]  <= regWrData[oneshot_pkg::CTRL_RLDWRAP];   // [R07]
      end else if (enableClr[i]) begin
        enable_q[i]   <= 1'b0;                                   // [R04]
      end
    end

    // Reload value; counter takes it only at start, reset or underflow
    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        reload_q[i] <= oneshot_pkg::RELOAD_RST;
      end else if (wrReload[i]) begin
        reload_q[i] <= regWrData;                                // [R14]
      end
    end

    shot_unit uShot (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .tick       (tick),
      .prevOvf    (chain[i]),
      .eventPin   (timerEventInputPin[i]),
      .enable     (enable_q[i]),
      .startSel   (startSel_q[i]),
      .extTrig    (extTrig_q[i]),
      .eventMode  (evtMode_q[i]),
      .timerReset (rstPulse[i]),
      .reloadVal  (reload_q[i]),
      .count      (count[i]),
      .running    (running[i]),
      .underflow  (underflow[i]),
      .enableClr  (enableClr[i])
    );

    assign chain[i+1] = underflow[i];                            // [R17]

    // Start always loads the reload value
    chk_start_loads: assert property (@(posedge core_clk) disable iff (!rst_b) // [R05]
      $rose(running[i]) |-> count[i] == $past(reload_q[i]))
      else $error("shot start did not load reload value");

    // Enable falls right after the automatic clear
    chk_enable_autoclear: assert property (@(posedge core_clk) disable iff (!rst_b) // [R04]
      enableClr[i] && !wrCtrl[i] |=> !enable_q[i] ##1 running[i] || !enable_q[i])
      else $error("enable not cleared after first tick");

    // Exactly one decrement per timer tick while running
    chk_count_down: assert property (@(posedge core_clk) disable iff (!rst_b) // [R18]
      running[i] && tick && !evtMode_q[i] && count[i] != 16'h0000 && !rstPulse[i]
      |=> count[i] == $past(count[i]) - 16'h0001)
      else $error("counter did not decrement by one");

    // Underflow halts the shot and drops the pulse output
    chk_underflow_halts: assert property (@(posedge core_clk) disable iff (!rst_b) // [R06] [R11]
      underflow[i] |=> !running[i] && count[i] == $past(reload_q[i])
        ##1 !timerPulseOutputPin[i])
      else $error("counter kept running after underflow");

    // Underflow raises the sticky interrupt flag
    chk_irq_flag: assert property (@(posedge core_clk) disable iff (!rst_b) // [R09] [R01]
      underflow[i] |=> status_q[i])
      else $error("underflow did not set interrupt flag");

    // Reset bit stops counting and copies reload
    chk_reset_copies: assert property (@(posedge core_clk) disable iff (!rst_b) // [R13] [R08]
      rstPulse[i] |=> !running[i] && count[i] == $past(reload_q[i]) && !enable_q[i])
      else $error("reset bit did not reload counter");

    // No shot begins without enable
    chk_no_start_idle: assert property (@(posedge core_clk) disable iff (!rst_b) // [R02]
      !enable_q[i] && !running[i] |=> !running[i])
      else $error("shot started with enable clear");

    // Flag stays set until written with a one
    chk_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_b) // [R18]
      status_q[i] && !(wrStatus && regWrData[i]) |=> status_q[i])
      else $error("interrupt flag lost without clear");
  end

  // Pulse output follows the running state, one pulse per shot
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timerPulseOutputPin <= '0;
    end else begin
      timerPulseOutputPin <= running;                            // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= '0;
      mask_q   <= oneshot_pkg::MASK_RST;
    end else begin
      status_q <= (status_q & ~({N{wrStatus}} & regWrData[N-1:0])) | underflow; // [R01] [R18]
      if (wrMask) begin
        mask_q <= regWrData[N-1:0];
      end
    end
  end

  assign irq = |(status_q & mask_q);                              // [R09]

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Register select for the read mux
  logic [CW-1:0] rdSel;
  always_comb begin
    rdSel = '0;
    if (inTimers) begin
      case (rSel)
        oneshot_pkg::REG_CTRL:   rdSel = ctrlView[tSel];
        oneshot_pkg::REG_RELOAD: rdSel = reload_q[tSel];
        oneshot_pkg::REG_COUNT:  rdSel = count[tSel];             // [R12]
        default:                 rdSel = '0;
      endcase
    end else if (regAddr == oneshot_pkg::REG_STATUS) begin
      rdSel = {12'h000, status_q};
    end else if (regAddr == oneshot_pkg::REG_MASK) begin
      rdSel = {12'h000, mask_q};
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= regRdEn ? rdSel : '0;
    end
  end

  assign regRdData = rdData_q;

  // Count reads return the live counter
  chk_read_count: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
    regRdEn && inTimers && rSel == oneshot_pkg::REG_COUNT
    |=> regRdData == $past(count[tSel]))
    else $error("count read did not return counter value");

  // Interrupt line rises after any unmasked underflow
  chk_irq_level: assert property (@(posedge core_clk) disable iff (!rst_b) // [R09]
    (underflow & mask_q) != '0 && !wrMask |=> irq)
    else $error("unmasked flag did not raise interrupt");

endmodule : oneshot_timer

// ---- common/oneshot_pkg.sv ----
// Purpose: Shared constants and types for the chained one-shot timer block
// Assumes: 100 MHz core clock, 16-bit register port
// Notes:   Offsets are byte addresses on the plain register port
package oneshot_pkg;

  // Geometry
  localparam int TIMERS = 4;
  localparam int CW     = 16;

  // Register map: per-timer window, timer index in address bits 5:4
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_RELOAD   = 4'h4;
  localparam logic [3:0] REG_COUNT    = 4'h8;
  localparam logic [7:0] REG_STATUS   = 8'h40;
  localparam logic [7:0] REG_MASK     = 8'h44;

  // Control register fields
  localparam int CTRL_ENABLE   = 0;
  localparam int CTRL_RESET    = 1;
  localparam int CTRL_STARTSEL = 2;
  localparam int CTRL_EXTTRIG  = 3;
  localparam int CTRL_EVTMODE  = 4;
  localparam int CTRL_RLDWRAP  = 5;
  localparam int CTRL_RUNNING  = 8;

  // Reset values
  localparam logic [CW-1:0]     RELOAD_RST = 16'h0000;
  localparam logic [CW-1:0]     COUNT_RST  = 16'h0000;
  localparam logic [TIMERS-1:0] MASK_RST   = 4'h0;

  // Timer tick period
  localparam int CLK_NS   = 10;
  localparam int TICK_NS  = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  // Shot state
  typedef enum logic {
    SHOT_IDLE,
    SHOT_RUN
  } shot_state_t;

endpackage : oneshot_pkg

// ---- rtl/tick_divider.sv ----
// Purpose: Divides the core clock down to the timer tick enable
// Assumes: One clock domain
// Notes:   Tick is a one-cycle pulse every TICK_CYC cycles
`timescale 1ns/10ps
module tick_divider (
  input  wire logic core_clk,
  input  wire logic rst_b,
  output logic      tickPulse
);

  localparam int W = $clog2(oneshot_pkg::TICK_CYC);
  localparam logic [W-1:0] LAST = W'(oneshot_pkg::TICK_CYC - 1);

  logic [W-1:0] div_q;
  logic         tick_q;
  wire          wrapNow = (div_q == LAST);

  // Free-running divider with registered tick
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= wrapNow ? '0 : div_q + 1'b1;
      tick_q <= wrapNow;
    end
  end

  assign tickPulse = tick_q;

endmodule : tick_divider

// ---- rtl/shot_unit.sv ----
// Purpose: One 16-bit one-shot down counter of the chain
// Assumes: Inputs synchronous to core_clk; control bits held by the register file
// Notes:   Underflow pulse doubles as the chain output to the next timer
`timescale 1ns/10ps
module shot_unit (
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic                      tick,
  input  wire logic                      prevOvf,
  input  wire logic                      eventPin,
  input  wire logic                      enable,
  input  wire logic                      startSel,
  input  wire logic                      extTrig,
  input  wire logic                      eventMode,
  input  wire logic                      timerReset,
  input  wire logic [oneshot_pkg::CW-1:0] reloadVal,
  output logic      [oneshot_pkg::CW-1:0] count,
  output logic                           running,
  output logic                           underflow,
  output logic                           enableClr
);

  oneshot_pkg::shot_state_t state_q;
  logic [oneshot_pkg::CW-1:0] count_q;
  logic                       first_q;
  logic                       pin_q;

  // Tick source, trigger and start decode
  wire countTick = eventMode ? prevOvf : tick;                   // [R10]
  wire pinRise   = eventPin & ~pin_q;
  wire trigger   = extTrig ? pinRise : prevOvf;                  // [R16]
  wire isRun     = (state_q == oneshot_pkg::SHOT_RUN);
  wire startNow  = ~isRun & enable & (~startSel | trigger);      // [R02] [R03]
  wire atZero    = (count_q == '0);

  // Shot sequencing; software reset has priority
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= oneshot_pkg::SHOT_IDLE;
      count_q <= oneshot_pkg::COUNT_RST;
      first_q <= 1'b0;
      pin_q   <= 1'b0;
    end else begin
      pin_q <= eventPin;
      if (timerReset) begin
        state_q <= oneshot_pkg::SHOT_IDLE;                       // [R08]
        count_q <= reloadVal;                                    // [R13]
        first_q <= 1'b0;
      end else if (startNow) begin
        state_q <= oneshot_pkg::SHOT_RUN;
        count_q <= reloadVal;                                    // [R05]
        first_q <= 1'b1;
      end else if (isRun && countTick) begin
        first_q <= 1'b0;
        if (atZero) begin
          state_q <= oneshot_pkg::SHOT_IDLE;                     // [R06] [R08]
          count_q <= reloadVal;                                  // [R14]
        end else begin
          count_q <= count_q - 16'h0001;                         // [R18]
        end
      end
    end
  end

  // Event outputs
  assign underflow = isRun & countTick & atZero & ~timerReset;   // [R09]
  assign enableClr = first_q & countTick & ~timerReset;          // [R04]
  assign running   = isRun;                                      // [R11]
  assign count     = count_q;

endmodule : shot_unit

// ---- testbench/prev_timer_model.sv ----
// Purpose: Preceding timer of the chain, seen from timer 0
// Assumes: Same core clock as the block
// Notes:   One-cycle overflow pulse every PERIOD cycles while runEn is high
`timescale 1ns/10ps
module prev_timer_model #(
  parameter int PERIOD = 20
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic runEn,
  output logic      ovfPulse
);
  logic [7:0] cnt_q;

  // Divider restarts whenever the model is paused
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q    <= 8'h00;
      ovfPulse <= 1'b0;
    end else begin
      ovfPulse <= runEn && (cnt_q == 8'(PERIOD - 1));
      cnt_q    <= (!runEn || cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule : prev_timer_model

// ---- testbench/tb_oneshot_timer.sv ----
// Purpose: Self-checking bench for the chained one-shot timers
// Assumes: Tick every 100 core cycles, registers masked through irq
// Notes:   Short reloads keep every shot a few hundred cycles long
`timescale 1ns/10ps
module tb_oneshot_timer;
  logic                           core_clk;
  logic                           rst_b;
  logic [7:0]                     regAddr;
  logic [oneshot_pkg::CW-1:0]     regWrData;
  logic                           regWrEn;
  logic                           regRdEn;
  logic [oneshot_pkg::CW-1:0]     regRdData;
  logic                           chainIn;
  logic [oneshot_pkg::TIMERS-1:0] evtPin;
  logic [oneshot_pkg::TIMERS-1:0] pulsePin;
  logic                           chainOut;
  logic                           irq;
  logic                           prevRun;
  logic                           sawChain;
  int                             n_fail;
  int                             n_tests;
  int                             cycles;
  int                             waited;

  oneshot_timer DUT (
    .core_clk            (core_clk),
    .rst_b               (rst_b),
    .regAddr             (regAddr),
    .regWrData           (regWrData),
    .regWrEn             (regWrEn),
    .regRdEn             (regRdEn),
    .regRdData           (regRdData),
    .chainIn             (chainIn),
    .timerEventInputPin  (evtPin),
    .timerPulseOutputPin (pulsePin),
    .chainOut            (chainOut),
    .irq                 (irq)
  );

  prev_timer_model prevTimer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .runEn    (prevRun),
    .ovfPulse (chainIn)
  );

  ////////////////////////////////////////
  // Clock, hang guard and chain monitor
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (rst_b !== 1'b1) sawChain <= 1'b0;
    else if (chainOut === 1'b1) sawChain <= 1'b1;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  ////////////////////////////////////////
  // Register port tasks and checks
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge core_clk);
    regWrEn   <= 1'b0;
  endtask : wr

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Read data stand in the cycle after the strobe only
  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp, input string msg);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 chk(regRdData, exp, msg);
  endtask : rdChk

  task automatic bitChk(input logic b, input logic e, input string msg);
    chk({15'h0000, b}, {15'h0000, e}, msg);
  endtask : bitChk

  task automatic waitIrq(input int lim);
    waited = 0;
    while (irq !== 1'b1 && waited < lim) begin
      @(posedge core_clk);
      waited++;
    end
    #1 bitChk(irq, 1'b1, "irq wait");
  endtask : waitIrq

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    rst_b     = 1'b0;
    regAddr   = 8'h00;
    regWrData = 16'h0000;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    evtPin    = 4'h0;
    prevRun   = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    rdChk(8'h04, 16'h0000, "reload reset");
    rdChk(8'h38, 16'h0000, "count3 reset");
    rdChk(8'h44, 16'h0000, "mask reset");
    rdChk(8'h0C, 16'h0000, "unmapped read");
    wr(8'h44, 16'h000F);
    rdChk(8'h44, 16'h000F, "mask write");
    // Software shot, second pass with reload-on-wrap set
    for (int k = 0; k < 2; k++) begin
      wr(8'h04, 16'h0002);
      wr(8'h00, k ? 16'h0021 : 16'h0001);
      repeat (2) @(posedge core_clk);
      #1 bitChk(pulsePin[0], 1'b1, "pulse high");
      waitIrq(400);
      bitChk(waited > 200 && waited <= 300, 1'b1, "shot length");
      rdChk(8'h08, 16'h0002, "halt at reload");
      bitChk(pulsePin[0], 1'b0, "pulse low");
      rdChk(8'h00, k ? 16'h0020 : 16'h0000, "enable cleared");
      repeat (300) @(posedge core_clk);
      rdChk(8'h08, 16'h0002, "no restart");
      bitChk(irq, 1'b1, "irq sticky");
      wr(8'h40, 16'h0001);
      #1 bitChk(irq, 1'b0, "irq cleared");
    end
    // Event pin trigger on timer 1, first while enable is clear
    wr(8'h14, 16'h0001);
    wr(8'h10, 16'h000C);
    evtPin[1] <= 1'b1;
    repeat (3) @(posedge core_clk);
    evtPin[1] <= 1'b0;
    rdChk(8'h10, 16'h000C, "trigger ignored");
    wr(8'h10, 16'h000D);
    repeat (3) @(posedge core_clk);
    #1 bitChk(pulsePin[1], 1'b0, "await trigger");
    evtPin[1] <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 bitChk(pulsePin[1], 1'b1, "pin start");
    evtPin[1] <= 1'b0;
    waitIrq(300);
    rdChk(8'h40, 16'h0002, "status timer1");
    wr(8'h40, 16'h0002);
    // Start on preceding overflow, then count on ticks
    wr(8'h04, 16'h0001);
    wr(8'h00, 16'h0005);
    repeat (50) @(posedge core_clk);
    #1 bitChk(pulsePin[0], 1'b0, "await overflow");
    prevRun <= 1'b1;
    repeat (25) @(posedge core_clk);
    #1 bitChk(pulsePin[0], 1'b1, "chain start");
    prevRun <= 1'b0;
    waitIrq(300);
    wr(8'h40, 16'h0001);
    // Event mode: ticks ignored, overflows count
    wr(8'h04, 16'h0002);
    wr(8'h00, 16'h0011);
    repeat (400) @(posedge core_clk);
    #1 bitChk(irq, 1'b0, "ticks ignored");
    prevRun <= 1'b1;
    waitIrq(100);
    prevRun <= 1'b0;
    wr(8'h40, 16'h0001);
    // Reset bit mid-shot copies new reload and stops
    wr(8'h04, 16'h0009);
    wr(8'h00, 16'h0001);
    repeat (150) @(posedge core_clk);
    wr(8'h04, 16'h0005);
    wr(8'h00, 16'h0002);
    rdChk(8'h08, 16'h0005, "reset loads");
    rdChk(8'h00, 16'h0000, "reset stops");
    repeat (1000) @(posedge core_clk);
    rdChk(8'h08, 16'h0005, "stays stopped");
    bitChk(irq, 1'b0, "no irq after reset");
    // New reload without reset enters at underflow
    wr(8'h04, 16'h0003);
    wr(8'h00, 16'h0001);
    repeat (150) @(posedge core_clk);
    wr(8'h04, 16'h0001);
    waitIrq(500);
    rdChk(8'h08, 16'h0001, "late reload");
    wr(8'h40, 16'h0001);
    // Timer 3 underflow drives chain out; masked status
    bitChk(sawChain, 1'b0, "chain quiet");
    wr(8'h44, 16'h0007);
    wr(8'h34, 16'h0000);
    wr(8'h30, 16'h0001);
    repeat (2) @(posedge core_clk);
    #1 bitChk(pulsePin[3], 1'b1, "pulse timer3");
    repeat (248) @(posedge core_clk);
    #1 bitChk(irq, 1'b0, "masked");
    bitChk(sawChain, 1'b1, "chain out");
    rdChk(8'h40, 16'h0008, "status timer3");
    wr(8'h44, 16'h000F);
    #1 bitChk(irq, 1'b1, "unmasked");
    wr(8'h40, 16'h0008);
    #1 bitChk(irq, 1'b0, "final clear");
    give_verdict();
  end
endmodule : tb_oneshot_timer
